//--- verilog/pio_port_mux.sv
// pio_port_mux: three-port gpio block with per-pin function multiplexer
// assumes: apb master on core_clk, pins and peripherals synchronous-ish,
// external pad cells resolve pin level from pin_out and pin_oe_n
//
// Functional notes
// - three ports of 8, 6, 10 pins
// - mode bits 4:0 select function 0x00-0x1F
// - function zero uses data/set/clear registers
// - shared peripheral input from lowest-numbered pin
// - direction bits 9:8 pick input/pull/output
// - output or analog pins disable pulls
// - data read is input, write is output
// - data read shows live pins, analog zero
// - data write updates general-purpose outputs
// - set register raises bits written one
// - clear register lowers bits written one
// - debug clock/data on port1 bits 4,5
// - decoder phases on even/odd pairs, selectable
// - four analog inputs on port0 bits 0-3
// - pins hold last state during sleep
`default_nettype none
module pio_port_mux
    import pio_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // package pins
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe_n,
    output logic [NPINS-1:0] pull_up_en,
    output logic [NPINS-1:0] pull_down_en,
    output logic [NADC-1:0] analog_en,
    // on-chip peripherals, indexed by function selector
    input wire logic [NFUNC-1:0] periph_out,
    output logic [NFUNC-1:0] periph_in,
    // debug wires and system control
    input wire logic debug_wire_enable,
    input wire logic dbg_swdio_out,
    input wire logic dbg_swdio_oe_n,
    output logic swd_clk,
    output logic swdio_in,
    // quadrature decoder
    input wire logic [NQDEC-1:0][3:0] decoder_channel_pin_select,
    output logic [NQDEC-1:0] decoder_phase_a,
    output logic [NQDEC-1:0] decoder_phase_b,
    // sleep retention
    input wire logic sleep_hold
);

    // first pin and pin mask of a port
    function automatic int port_base(input int p);
        port_base = (p == 0) ? 0 : (p == 1) ? PORT1_BASE : PORT2_BASE;
    endfunction

    function automatic logic [NPINS-1:0] port_mask(input int p);
        logic [NPINS-1:0] m;
        m = '0;
        for (int i = 0; i < NPINS; i++) begin
            if (i >= port_base(p) && (p == NPORTS - 1 || i < port_base(p + 1)))
                m[i] = 1'b1;
        end
        port_mask = m;
    endfunction

    // address decode shared by read and write paths
    function automatic pio_dec_s pio_decode(input logic [11:0] a);
        pio_dec_s d;
        logic [11:0] rel;
        d.hit = 1'b0;
        d.kind = PIO_K_DATA;
        d.idx = 5'h00;
        rel = a - MODE_BASE;
        if (a[1:0] == 2'b00) begin
            if (a >= MODE_BASE && a < MODE_END) begin
                d.hit = 1'b1;
                d.kind = PIO_K_MODE;
                d.idx = rel[6:2];
            end else if (a < PORT_STRIDE * 3 && a[3:2] != 2'b11) begin
                d.hit = 1'b1;
                d.idx = {3'b000, a[5:4]};
                unique case (a[3:0])
                    DATA_OFS[3:0]: d.kind = PIO_K_DATA;
                    SET_OFS[3:0]: d.kind = PIO_K_SET;
                    CLR_OFS[3:0]: d.kind = PIO_K_CLR;
                    default: d.hit = 1'b0;
                endcase
            end
        end
        pio_decode = d;
    endfunction

    pio_state_s st;
    pio_state_s next_st;

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;

    // next-state logic for the whole block
    always_comb begin
        pio_dec_s dec;
        logic [NPINS-1:0] ana;
        logic [NPINS-1:0] drv;
        logic [NPINS-1:0] oen;
        logic [NPINS-1:0] pu;
        logic [NPINS-1:0] pd;
        logic [NPINS-1:0] pm;
        logic [NPINS-1:0] wv;
        logic [4:0] f;
        logic [1:0] dir;
        logic [3:0] ps;
        int pb;
        dec = pio_decode(paddr);
        ana = '0;
        drv = '0;
        oen = '1;
        pu = '0;
        pd = '0;
        pm = '0;
        wv = '0;
        f = 5'h00;
        dir = DIR_IN;
        ps = 4'h0;
        pb = 0;
        next_st = st;
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        // per-pin drive, direction and pull decode
        for (int i = 0; i < NPINS; i++) begin
            f = st.mode[i][FSEL_MSB:FSEL_LSB];
            dir = st.mode[i][DIR_MSB:DIR_LSB];
            ana[i] = (i < NADC) && (f == FUNC_ADC);
            drv[i] = (f == FUNC_GPIO) ? st.out_data[i] : periph_out[f];
            oen[i] = !(dir == DIR_OUT) || ana[i];
            pu[i] = (dir == DIR_IN_PU) && !ana[i];
            pd[i] = (dir == DIR_IN_PD) && !ana[i];
        end
        // debug wires take over port1 bits 4 and 5
        if (debug_wire_enable) begin
            oen[PORT1_BIT4] = 1'b1;
            pu[PORT1_BIT4] = 1'b0;
            pd[PORT1_BIT4] = 1'b0;
            drv[PORT1_BIT5] = dbg_swdio_out;
            oen[PORT1_BIT5] = dbg_swdio_oe_n;
            pu[PORT1_BIT5] = 1'b0;
            pd[PORT1_BIT5] = 1'b0;
        end
        // pads keep their last state while sleep_hold is high
        if (!sleep_hold) begin
            next_st.pin_out = drv;
            next_st.pin_oe_n = oen;
            next_st.pull_up = pu;
            next_st.pull_down = pd;
            next_st.analog_en = ana[NADC-1:0];
        end
        // peripheral inputs: walk down so the lowest pin wins
        next_st.periph_in = '0;
        for (int i = NPINS - 1; i >= 0; i--) begin
            f = st.mode[i][FSEL_MSB:FSEL_LSB];
            if (f != FUNC_GPIO && !ana[i])
                next_st.periph_in[f] = st.sync2[i];
        end
        next_st.swd_clk = debug_wire_enable & st.sync2[PORT1_BIT4];
        next_st.swdio_in = debug_wire_enable & st.sync2[PORT1_BIT5];
        // decoder phases from the selected even/odd pin pair
        for (int c = 0; c < NQDEC; c++) begin
            ps = decoder_channel_pin_select[c];
            if (ps > 4'hB)
                ps = 4'hB;
            next_st.phase_a[c] = st.sync2[{ps, 1'b0}];
            next_st.phase_b[c] = st.sync2[{ps, 1'b1}];
        end
        // apb setup cycle: capture read data and error for the access
        if (psel && !penable) begin
            next_st.prdata = '0;
            next_st.pslverr = !dec.hit;
            if (dec.hit && !pwrite) begin
                if (dec.kind == PIO_K_MODE) begin
                    next_st.prdata[9:0] = st.mode[dec.idx];
                end else if (dec.kind == PIO_K_DATA) begin
                    pb = port_base(int'(dec.idx));
                    wv = (st.sync2 & ~ana) >> pb;
                    next_st.prdata[NPINS-1:0] = wv & (port_mask(int'(dec.idx)) >> pb);
                end
            end
        end
        // apb access cycle: writes take effect here
        if (psel && penable && pwrite && dec.hit) begin
            pb = port_base(int'(dec.idx));
            pm = port_mask(int'(dec.idx));
            wv = pwdata[NPINS-1:0] << pb;
            unique case (dec.kind)
                PIO_K_DATA: next_st.out_data = (st.out_data & ~pm) | (wv & pm);
                PIO_K_SET: next_st.out_data = st.out_data | (wv & pm);
                PIO_K_CLR: next_st.out_data = st.out_data & ~(wv & pm);
                PIO_K_MODE: next_st.mode[dec.idx] = pwdata[9:0];
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= {NPINS{MODE_RESET}};
            st.out_data <= OUT_RESET;
            st.pin_oe_n <= '1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign pin_out = st.pin_out;
    assign pin_oe_n = st.pin_oe_n;
    assign pull_up_en = st.pull_up;
    assign pull_down_en = st.pull_down;
    assign analog_en = st.analog_en;
    assign periph_in = st.periph_in;
    assign swd_clk = st.swd_clk;
    assign swdio_in = st.swdio_in;
    assign decoder_phase_a = st.phase_a;
    assign decoder_phase_b = st.phase_b;

    // checks on the implementation
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_sync_two_stage: assert property (
        ($past(rst_n, 2) && $past(rst_n))
        |-> (st.sync2 == $past(pin_in, 2)))
        else $error("pin input not synchronised over two stages");

    a_pull_off_drive: assert property (
        (((~pin_oe_n) | {{(NPINS-NADC){1'b0}}, analog_en})
            & (pull_up_en | pull_down_en)) == '0)
        else $error("pull enabled on output or analog pin");

    a_set_bit_high: assert property (
        (psel && penable && pwrite && paddr == SET_OFS && pwdata[0])
        |=> st.out_data[0])
        else $error("set register did not raise bit");

    a_clr_bit_low: assert property (
        (psel && penable && pwrite && paddr == CLR_OFS && pwdata[0])
        |=> !st.out_data[0])
        else $error("clear register did not lower bit");

    a_data_write_out: assert property (
        (psel && penable && pwrite && paddr == DATA_OFS)
        |=> st.out_data[7:0] == $past(pwdata[7:0]))
        else $error("data write not stored");

    a_read_live_pins: assert property (
        (psel && !penable && !pwrite && paddr == DATA_OFS
            && st.mode[0][4:0] != FUNC_ADC)
        |=> prdata[0] == $past(st.sync2[0]))
        else $error("data read does not show pin level");

    a_gpio_drive_pin: assert property (
        (!sleep_hold && st.mode[3] == {DIR_OUT, 3'b000, FUNC_GPIO})
        |=> !pin_oe_n[3] && pin_out[3] == $past(st.out_data[3]))
        else $error("general-purpose output not driven");

    a_prio_lowest_pin: assert property (
        (st.mode[5][4:0] == 5'h07 && st.mode[6][4:0] == 5'h07)
        |=> periph_in[7] == $past(st.sync2[5]))
        else $error("lowest pin lost input priority");

    a_hold_in_sleep: assert property (
        sleep_hold |=> $stable(pin_out) && $stable(pin_oe_n))
        else $error("pins changed during sleep hold");

    a_debug_clk_route: assert property (
        debug_wire_enable |=> swd_clk == $past(st.sync2[PORT1_BIT4]))
        else $error("debug clock not routed from port1 bit4");

    a_debug_data_route: assert property (
        debug_wire_enable |=> swdio_in == $past(st.sync2[PORT1_BIT5]))
        else $error("debug data not routed from port1 bit5");

    a_debug_pin_drive: assert property (
        (!sleep_hold && debug_wire_enable)
        |=> pin_oe_n[PORT1_BIT4]
            && pin_oe_n[PORT1_BIT5] == $past(dbg_swdio_oe_n))
        else $error("debug pins not under debugger control");

    a_debug_off_zero: assert property (
        !debug_wire_enable |=> !swd_clk && !swdio_in)
        else $error("debug inputs active while disabled");

    a_read_analog_zero: assert property (
        (psel && !penable && !pwrite && paddr == DATA_OFS
            && st.mode[0][4:0] == FUNC_ADC)
        |=> prdata[0] == 1'b0)
        else $error("analog pin did not read as zero");

    a_analog_enable: assert property (
        (!sleep_hold && st.mode[0][4:0] == FUNC_ADC)
        |=> analog_en[0] && !pull_up_en[0] && !pull_down_en[0])
        else $error("analog pin not enabled or still pulled");

    a_input_pull_up: assert property (
        (!sleep_hold && st.mode[3] == {DIR_IN_PU, 3'b000, FUNC_GPIO})
        |=> pull_up_en[3] && !pull_down_en[3] && pin_oe_n[3])
        else $error("input with pull-up decoded wrongly");

    a_periph_drive_pin: assert property (
        (!sleep_hold && st.mode[7] == {DIR_OUT, 3'b000, 5'h09})
        |=> !pin_oe_n[7] && pin_out[7] == $past(periph_out[9]))
        else $error("peripheral output not driven on its pin");

    a_decoder_pair: assert property (
        decoder_channel_pin_select[0] <= 4'hB
        |=> decoder_phase_a[0]
                == $past(st.sync2[{decoder_channel_pin_select[0], 1'b0}])
            && decoder_phase_b[0]
                == $past(st.sync2[{decoder_channel_pin_select[0], 1'b1}]))
        else $error("decoder phases not from selected pin pair");

    c_set_write: cover property (psel && penable && pwrite
        && paddr == SET_OFS);
    c_pin_output: cover property (!pin_oe_n[3] ##1 pin_out[3]);
    c_analog_pin: cover property (analog_en[0]);
    c_debug_route: cover property (debug_wire_enable ##1 swd_clk);
    c_sleep_hold: cover property (sleep_hold ##1 sleep_hold);

endmodule
`default_nettype wire

//--- verilog/pio_pkg.sv
// pio_pkg: constants, register map and state layout of the pin mux block
// assumes: 24 pins numbered port 0 (0-7), port 1 (8-13), port 2 (14-23)
`default_nettype none
package pio_pkg;
    localparam int NPINS = 24;
    localparam int NPORTS = 3;
    localparam int NFUNC = 32;
    localparam int NQDEC = 3;
    // pin counts and first pin of each port
    localparam int PORT0_PINS = 8;
    localparam int PORT1_PINS = 6;
    localparam int PORT2_PINS = 10;
    localparam int PORT1_BASE = PORT0_PINS;
    localparam int PORT2_BASE = PORT0_PINS + PORT1_PINS;
    // serial wire debug pins: port 1 bits 4 and 5
    localparam int PORT1_BIT4 = PORT1_BASE + 4;
    localparam int PORT1_BIT5 = PORT1_BASE + 5;
    localparam int NADC = 4;
    // mode register fields
    localparam int FSEL_LSB = 0;
    localparam int FSEL_MSB = 4;
    localparam int DIR_LSB = 8;
    localparam int DIR_MSB = 9;
    localparam logic [4:0] FUNC_GPIO = 5'h00;
    localparam logic [4:0] FUNC_ADC = 5'h0F;
    localparam logic [1:0] DIR_IN = 2'h0;
    localparam logic [1:0] DIR_IN_PU = 2'h1;
    localparam logic [1:0] DIR_IN_PD = 2'h2;
    localparam logic [1:0] DIR_OUT = 2'h3;
    localparam logic [9:0] MODE_RESET = 10'h000;
    localparam logic [23:0] OUT_RESET = 24'h00_0000;
    // byte offsets: port p data/set/clear at PORT_STRIDE*p + 0/4/8
    localparam logic [11:0] PORT_STRIDE = 12'h010;
    localparam logic [11:0] DATA_OFS = 12'h000;
    localparam logic [11:0] SET_OFS = 12'h004;
    localparam logic [11:0] CLR_OFS = 12'h008;
    localparam logic [11:0] MODE_BASE = 12'h040;
    localparam logic [11:0] MODE_END = 12'h0A0;

    typedef enum logic [1:0] {
        PIO_K_DATA = 2'b00,
        PIO_K_SET = 2'b01,
        PIO_K_CLR = 2'b10,
        PIO_K_MODE = 2'b11
    } pio_kind_e;

    typedef struct packed {
        logic hit;
        pio_kind_e kind;
        logic [4:0] idx;
    } pio_dec_s;

    typedef struct packed {
        logic [NPINS-1:0][9:0] mode;
        logic [NPINS-1:0] out_data;
        logic [NPINS-1:0] sync1;
        logic [NPINS-1:0] sync2;
        logic [NPINS-1:0] pin_out;
        logic [NPINS-1:0] pin_oe_n;
        logic [NPINS-1:0] pull_up;
        logic [NPINS-1:0] pull_down;
        logic [NADC-1:0] analog_en;
        logic [NFUNC-1:0] periph_in;
        logic [NQDEC-1:0] phase_a;
        logic [NQDEC-1:0] phase_b;
        logic swd_clk;
        logic swdio_in;
        logic [31:0] prdata;
        logic pslverr;
    } pio_state_s;
endpackage
`default_nettype wire

//--- verification/pio_pins_model.sv
// pio_pins_model: pads and board seen from the pin mux block
// assumes: bench drives ext_en/ext_val on core_clk; a pin nobody drives
// floats and reads back a level that flips every cycle
`default_nettype none
module pio_pins_model
    import pio_pkg::*;
(
    // clock
    input wire logic core_clk,
    // from the block
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe_n,
    input wire logic [NPINS-1:0] pull_up_en,
    input wire logic [NPINS-1:0] pull_down_en,
    // board side drive
    input wire logic [NPINS-1:0] ext_en,
    input wire logic [NPINS-1:0] ext_val,
    // resolved pad levels
    output logic [NPINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NPINS-1:0] float_lvl = '0;
    // floating level flips so a stale value never passes as good
    always @(posedge core_clk) begin
        float_lvl <= ~pin_in;
    end
    // pad resolution: own drive, then board, then pull, else floating
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pin_oe_n[i] === 1'b0) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pull_up_en[i] === 1'b1) pin_in[i] = 1'b1;
            else if (pull_down_en[i] === 1'b1) pin_in[i] = 1'b0;
            else pin_in[i] = float_lvl[i];
        end
    end
endmodule
`default_nettype wire

//--- verification/tb_programmable_io_port_mux.sv
// tb_programmable_io_port_mux: register-level tests of the pin mux block
// assumes: pio_pins_model resolves the pads; apb answers via pready
`default_nettype none
module tb_programmable_io_port_mux
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NPINS-1:0] pin_in, pin_out, oe_n, pu, pd, ext_en, ext_val;
    logic [NADC-1:0] analog_en;
    logic [NFUNC-1:0] periph_out, periph_in;
    logic dbg_en, dbg_do, dbg_oe_n, swd_clk, swdio_in, sleep_hold;
    logic [NQDEC-1:0][3:0] qsel;
    logic [NQDEC-1:0] ph_a, ph_b;
    logic [11:0] ofs [3] = '{DATA_OFS, SET_OFS, CLR_OFS};
    logic [31:0] wv [3] = '{32'h0000_02A5, 32'h0000_000F, 32'h0000_0201};
    logic [31:0] ev [3] = '{32'h0000_02A5, 32'h0000_02AF, 32'h0000_00AE};
    int n_fail = 0;
    int n_compared = 0;
    // block under test
    pio_port_mux i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
        .pull_up_en(pu), .pull_down_en(pd), .analog_en(analog_en),
        .periph_out(periph_out), .periph_in(periph_in),
        .debug_wire_enable(dbg_en), .dbg_swdio_out(dbg_do),
        .dbg_swdio_oe_n(dbg_oe_n), .swd_clk(swd_clk), .swdio_in(swdio_in),
        .decoder_channel_pin_select(qsel), .decoder_phase_a(ph_a),
        .decoder_phase_b(ph_b), .sleep_hold(sleep_hold));
    // pads and board
    pio_pins_model i_pins (.core_clk(core_clk), .pin_out(pin_out),
        .pin_oe_n(oe_n), .pull_up_en(pu), .pull_down_en(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // compare one value, report and count a mismatch
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one apb transfer: setup, then access held until pready
    task automatic apb(input logic wr_en, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdr(input logic [11:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0000_0000, q);
    endtask
    // pin to register path takes three edges; leave margin
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask
    function automatic logic [11:0] ma(int n);
        return MODE_BASE + 12'(4 * n);
    endfunction
    task automatic wm(int n, logic [1:0] d, logic [4:0] f);
        wr(ma(n), 32'({d, 3'h0, f}));
    endtask
    // pins of port p as they read in its data register
    function automatic logic [31:0] pbits(int p, logic [NPINS-1:0] v);
        logic [31:0] w;
        w = 32'(v);
        if (p == 0) return w & 32'h0000_00FF;
        if (p == 1) return (w >> PORT1_BASE) & 32'h0000_003F;
        return (w >> PORT2_BASE) & 32'h0000_03FF;
    endfunction
    // clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #500us;
        n_fail++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        periph_out = '0;
        dbg_en = 1'b0;
        dbg_do = 1'b0;
        dbg_oe_n = 1'b1;
        sleep_hold = 1'b0;
        qsel = '0;
        ext_en = '1;
        ext_val = 24'hA5_3C97;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        chk(32'(oe_n), 32'h00FF_FFFF);
        for (int i = 0; i < NPINS; i++) begin
            rdr(ma(i), rd);
            chk(rd, 32'h0000_0000);
        end
        for (int p = 0; p < NPORTS; p++) begin
            rdr(PORT_STRIDE * 12'(p), rd);
            chk(rd, pbits(p, ext_val));
        end
        ext_en[3] <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            wm(3, 2'(d), FUNC_GPIO);
            settle();
            chk(32'({pu[3], pd[3], oe_n[3]}),
                32'({d == 1, d == 2, d != 3}));
        end
        wm(0, DIR_IN_PU, FUNC_ADC);
        settle();
        chk(32'({analog_en, pu[0]}), 32'h0000_0002);
        rdr(PORT_STRIDE * 12'(0), rd);
        chk(rd & 32'h0000_0001, 32'h0000_0000);
        wm(5, DIR_IN, 5'h07);
        wm(6, DIR_IN, 5'h07);
        for (int v = 0; v < 2; v++) begin
            ext_val[6:5] <= {v == 0, v == 1};
            settle();
            chk(32'(periph_in[7]), 32'(v));
        end
        // peripheral output 9 drives pin 7 once its mode selects function 9 with output direction
        ext_en[7] <= 1'b0;
        wm(7, DIR_OUT, 5'h09);
        for (int v = 0; v < 2; v++) begin
            periph_out[9] <= v[0];
            settle();
            chk(32'({oe_n[7], pin_out[7]}), 32'(v));
        end
        ext_en[13] <= 1'b0;
        dbg_en <= 1'b1;
        dbg_do <= 1'b1;
        dbg_oe_n <= 1'b0;
        settle();
        chk(32'({swd_clk, swdio_in, oe_n[13], pin_out[13]}),
            32'h0000_000D);
        dbg_en <= 1'b0;
        settle();
        chk(32'({swd_clk, swdio_in}), 32'h0000_0000);
        qsel <= {4'd0, 4'd15, 4'd9};
        settle();
        chk(32'({ph_b[1:0], ph_a[1:0]}), 32'({ext_val[23], ext_val[19],
            ext_val[22], ext_val[18]}));
        ext_en[23:14] <= '0;
        for (int n = PORT2_BASE; n < NPINS; n++) wm(n, DIR_OUT, FUNC_GPIO);
        for (int k = 0; k < 3; k++) begin
            wr(ofs[k], wv[k]);
            wr(PORT_STRIDE * 12'(2) + ofs[k], wv[k]);
            settle();
            chk(32'(pin_out[23:14]), ev[k]);
            chk(32'(pin_out[3]), 32'(ev[k][3]));
            rdr(PORT_STRIDE * 12'(2), rd);
            chk(rd, ev[k]);
        end
        sleep_hold <= 1'b1;
        wr(PORT_STRIDE * 12'(2), 32'h0000_0000);
        settle();
        chk(32'(pin_out[23:14]), 32'h0000_00AE);
        sleep_hold <= 1'b0;
        settle();
        chk(32'(pin_out[23:14]), 32'h0000_0000);
        rdr(12'h0FC, rd);
        chk({rd[30:0], err}, 32'h0000_0001);
        tally_and_finish();
    end
endmodule
`default_nettype wire
